// *** common/mrs_defines.vh ***
// Constants for the reset sequencer
`ifndef MRS_DEFINES_VH
`define MRS_DEFINES_VH
// Stabilization interval: 31.3 ms of the 40 MHz clock, in cycles
`define MRS_STAB_CYCLES 21'h13_1AA0
`define MRS_CNT_W 21
// Program memory vector addresses
`define MRS_VEC_HI_ADDR 14'h0000
`define MRS_VEC_LO_ADDR 14'h0001
`define MRS_ADDR_W 14
// Vector byte fields
`define MRS_ERB_BIT 6
`define MRS_EMB_BIT 7
`define MRS_PCH_MSB 5
// Reset values
`define MRS_SMB_RST 4'hF
`define MRS_SRB_RST 4'h0
// Sequencer states
`define MRS_ST_RESET 3'h0
`define MRS_ST_WAIT 3'h1
`define MRS_ST_FETCH_HI 3'h2
`define MRS_ST_FETCH_LO 3'h3
`define MRS_ST_RUN 3'h4
`endif

// *** core/mrs_sequencer.v ***
// Reset sequencer: idle hold, vector fetch and register reset strobes
`timescale 1ns/1ps
`include "mrs_defines.vh"
module mrs_sequencer #(
  parameter [`MRS_CNT_W-1:0] STAB_CYCLES = `MRS_STAB_CYCLES
) (
  // Clock and power-on reset
  input wire CLOCK,
  input wire RST_B,
  // External reset pin, active low, asynchronous to CLOCK
  input wire RESET_PIN_B,
  // Power-down status from the core
  input wire IDLE_MODE,
  input wire STOP_MODE,
  // Program memory read port
  output reg [`MRS_ADDR_W-1:0] PMEM_ADDR,
  output wire PMEM_RD,
  input wire [7:0] PMEM_DATA,
  // CPU control
  output wire CPU_IDLE,
  output wire REG_RESET,
  output reg RETAIN_STATE,
  output reg [13:0] PROGRAM_COUNTER,
  output reg PC_LOAD,
  output reg MEMORY_BANK_ENABLE,
  output reg REGISTER_BANK_ENABLE,
  // Reset values for the register file
  output wire [3:0] MEMORY_BANK_SELECT,
  output wire [3:0] REGISTER_BANK_SELECT,
  output wire [2:0] SKIP_FLAGS,
  output wire INTERRUPT_STATUS_BIT0,
  output wire INTERRUPT_STATUS_BIT1,
  output wire CLEAR_CARRIERS,
  output wire CLEAR_CLOCK_REGS,
  output wire CLEAR_INTERRUPTS,
  output wire CLEAR_EXT_INT_MODES
);
  localparam [2:0] ST_RESET = `MRS_ST_RESET;
  localparam [2:0] ST_WAIT = `MRS_ST_WAIT;
  localparam [2:0] ST_FETCH_HI = `MRS_ST_FETCH_HI;
  localparam [2:0] ST_FETCH_LO = `MRS_ST_FETCH_LO;
  localparam [2:0] ST_RUN = `MRS_ST_RUN;
  localparam [`MRS_CNT_W-1:0] CNT_ONE = {{(`MRS_CNT_W-1){1'b0}}, 1'b1};
  localparam [`MRS_CNT_W-1:0] CNT_ZERO = {`MRS_CNT_W{1'b0}};
  localparam [`MRS_CNT_W-1:0] STAB_LAST = STAB_CYCLES - CNT_ONE;

  wire pin_b_s;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`MRS_CNT_W-1:0] cnt_r;
  reg [7:0] hi_byte_r;
  reg pin_b_d_r;

  mrs_sync u_sync (
    .CLOCK(CLOCK),
    .RST_B(RST_B),
    .d(RESET_PIN_B),
    .q(pin_b_s)
  );

  // Synced pin low, and its falling edge in the same cycle as the sync output falls
  wire pin_low;
  wire pin_fall;
  wire wait_done;
  wire vec_load;
  wire powered_down;

  assign pin_low = ~pin_b_s;
  assign pin_fall = pin_b_d_r & pin_low;
  assign wait_done = (cnt_r == STAB_LAST);
  // Vector taken only if the pin is still high in the last fetch
  assign vec_load = (state_r == ST_FETCH_LO) & pin_b_s;
  // Either power-down mode counts
  assign powered_down = IDLE_MODE | STOP_MODE;

  // Next state; a low pin wins over every other branch
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET: begin
        if (pin_b_s)
          state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (wait_done)
          state_nxt = ST_FETCH_HI;
      end
      ST_FETCH_HI: begin
        state_nxt = ST_FETCH_LO;
      end
      ST_FETCH_LO: begin
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
    if (pin_low)
      state_nxt = ST_RESET;
  end

  // State register
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Resets low like the sync, so no false fall follows reset
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pin_b_d_r <= 1'b0;
    end else begin
      pin_b_d_r <= pin_b_s;
    end
  end

  // Power-on reset never retains; a pin reset retains if powered down
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      RETAIN_STATE <= 1'b0;
    end else if (pin_fall) begin
      RETAIN_STATE <= powered_down;
    end
  end

  // Counter runs only in the wait state, so the wait tracks the clock
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_r <= CNT_ZERO;
    end else if (state_r == ST_WAIT) begin
      cnt_r <= cnt_r + CNT_ONE;
    end else begin
      cnt_r <= CNT_ZERO;
    end
  end

  // Address is registered on the same edge as the read strobe state
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      PMEM_ADDR <= `MRS_VEC_HI_ADDR;
    end else if (state_nxt == ST_FETCH_HI) begin
      PMEM_ADDR <= `MRS_VEC_HI_ADDR;
    end else if (state_r == ST_FETCH_HI) begin
      PMEM_ADDR <= `MRS_VEC_LO_ADDR;
    end
  end

  // First vector byte, held until the second arrives
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      hi_byte_r <= 8'h00;
    end else if (state_r == ST_FETCH_HI) begin
      hi_byte_r <= PMEM_DATA;
    end
  end

  // Program counter from both vector bytes
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      PROGRAM_COUNTER <= 14'h0000;
    end else if (vec_load) begin
      PROGRAM_COUNTER <= {hi_byte_r[`MRS_PCH_MSB:0], PMEM_DATA};
    end
  end

  // Bank enable flags from the top bits of the first byte
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      REGISTER_BANK_ENABLE <= 1'b0;
      MEMORY_BANK_ENABLE <= 1'b0;
    end else if (vec_load) begin
      REGISTER_BANK_ENABLE <= hi_byte_r[`MRS_ERB_BIT];
      MEMORY_BANK_ENABLE <= hi_byte_r[`MRS_EMB_BIT];
    end
  end

  // One-cycle load strobe for the core
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      PC_LOAD <= 1'b0;
    end else begin
      PC_LOAD <= vec_load;
    end
  end

  // Memory read is combinational, with the address valid in the same cycle
  assign PMEM_RD = (state_r == ST_FETCH_HI) | (state_r == ST_FETCH_LO);

  // CPU held idle from reset until the vector is loaded
  assign CPU_IDLE = (state_r != ST_RUN);
  assign REG_RESET = (state_r == ST_RESET);

  // Constant reset values, applied by the core while REG_RESET is high
  assign MEMORY_BANK_SELECT = `MRS_SMB_RST;
  assign REGISTER_BANK_SELECT = `MRS_SRB_RST;

  // Status word flags; the stack pointer is left alone
  assign SKIP_FLAGS = 3'h0;
  assign INTERRUPT_STATUS_BIT0 = 1'b0;
  assign INTERRUPT_STATUS_BIT1 = 1'b0;

  // Register clears follow the reset state
  assign CLEAR_CARRIERS = REG_RESET;
  assign CLEAR_CLOCK_REGS = REG_RESET;
  assign CLEAR_INTERRUPTS = REG_RESET;
  assign CLEAR_EXT_INT_MODES = REG_RESET;
endmodule // mrs_sequencer

// *** core/mrs_sync.v ***
// Two-flop synchroniser for the reset pin
`timescale 1ns/1ps
module mrs_sync (
  // Clock and reset
  input wire CLOCK,
  input wire RST_B,
  // Level
  input wire d,
  output reg q
);
  reg meta_r;
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // mrs_sync

// *** verification/mrs_pmem.sv ***
// Program memory model holding the reset vector
`timescale 1ns/1ps
module mrs_pmem #(parameter [7:0] B0 = 8'hA5, B1 = 8'h3C) (
  input wire clock, rd,
  input wire [13:0] addr,
  output wire [7:0] data
);
  reg junk_r = 1'b0;
  always @(posedge clock) junk_r <= ~junk_r;
  // Toggling when unread, so a stale byte never looks valid
  assign data = rd ? (addr[0] ? B1 : B0) : {8{junk_r}};
endmodule // mrs_pmem

// *** verification/mrs_props.sv ***
// Assertions for the reset sequencer
`timescale 1ns/1ps
module mrs_props #(parameter [20:0] STAB_CYCLES = 21'h13_1AA0) (
  input wire CLOCK, RST_B, CPU_IDLE, REG_RESET, PC_LOAD, PMEM_RD,
  input wire MEMORY_BANK_ENABLE, REGISTER_BANK_ENABLE,
  input wire [13:0] PMEM_ADDR, PROGRAM_COUNTER,
  input wire [7:0] PMEM_DATA,
  input wire [2:0] SKIP_FLAGS
);
  reg [7:0] hi_r;
  reg [20:0] wait_r;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  always @(posedge CLOCK) begin
    if (PMEM_RD && !PMEM_ADDR[0]) hi_r <= PMEM_DATA;
    wait_r <= REG_RESET ? 21'h0 : wait_r + 21'h1;
  end
  property p_idle; REG_RESET |-> CPU_IDLE; endproperty
  a_idle: assert property (p_idle) else $error("ran");
  property p_wait; $fell(CPU_IDLE) |-> wait_r >= STAB_CYCLES; endproperty
  a_wait: assert property (p_wait) else $error("early");
  property p_seq; $rose(PMEM_RD) |-> !PMEM_ADDR ##1 PMEM_ADDR[0]; endproperty
  a_seq: assert property (p_seq) else $error("order");
  property p_pc; PC_LOAD |-> PROGRAM_COUNTER[7:0] == $past(PMEM_DATA); endproperty
  a_pc: assert property (p_pc) else $error("pc lo");
  property p_pch; PC_LOAD |-> PROGRAM_COUNTER[13:8] == hi_r[5:0]; endproperty
  a_pch: assert property (p_pch) else $error("pc hi");
  property p_emb; PC_LOAD |-> MEMORY_BANK_ENABLE == hi_r[7]; endproperty
  a_emb: assert property (p_emb) else $error("emb");
  property p_erb; PC_LOAD |-> REGISTER_BANK_ENABLE == hi_r[6]; endproperty
  a_erb: assert property (p_erb) else $error("erb");
  property p_skip; REG_RESET |-> SKIP_FLAGS == 3'h0; endproperty
  a_skip: assert property (p_skip) else $error("skip");
endmodule // mrs_props
bind mrs_sequencer mrs_props #(.STAB_CYCLES(STAB_CYCLES)) u_props (
  .CLOCK(CLOCK), .RST_B(RST_B), .CPU_IDLE(CPU_IDLE), .REG_RESET(REG_RESET),
  .PC_LOAD(PC_LOAD), .PMEM_RD(PMEM_RD),
  .MEMORY_BANK_ENABLE(MEMORY_BANK_ENABLE),
  .REGISTER_BANK_ENABLE(REGISTER_BANK_ENABLE), .PMEM_ADDR(PMEM_ADDR),
  .PROGRAM_COUNTER(PROGRAM_COUNTER), .PMEM_DATA(PMEM_DATA),
  .SKIP_FLAGS(SKIP_FLAGS));

// *** verification/testbench.sv ***
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
module testbench;
  reg CLOCK = 1'b0, RST_B = 1'b0, RESET_PIN_B = 1'b1;
  reg IDLE_MODE = 1'b0, STOP_MODE = 1'b0;
  wire [13:0] PMEM_ADDR, PROGRAM_COUNTER;
  wire [7:0] PMEM_DATA;
  wire [3:0] MEMORY_BANK_SELECT, REGISTER_BANK_SELECT;
  wire [2:0] SKIP_FLAGS;
  wire PMEM_RD, CPU_IDLE, REG_RESET, RETAIN_STATE, PC_LOAD, CLEAR_CARRIERS;
  wire MEMORY_BANK_ENABLE, REGISTER_BANK_ENABLE, CLEAR_CLOCK_REGS;
  wire INTERRUPT_STATUS_BIT0, INTERRUPT_STATUS_BIT1, CLEAR_INTERRUPTS;
  wire CLEAR_EXT_INT_MODES;
  integer error_cnt = 0, checks = 0, n;
  // Short interval keeps the run small; the count logic is the same
  localparam [20:0] STAB = 21'h00_03E8;
  always #12.5 CLOCK = ~CLOCK;
  mrs_sequencer #(.STAB_CYCLES(STAB)) dut (.*);
  mrs_pmem pm (.clock(CLOCK), .rd(PMEM_RD), .addr(PMEM_ADDR),
    .data(PMEM_DATA));
  task chk(input [31:0] nm, input [23:0] seen, exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task t_pin(input i, s, e);
    begin
      @(posedge CLOCK);
      IDLE_MODE <= i;
      STOP_MODE <= s;
      RESET_PIN_B <= 1'b0;
      repeat (6) @(posedge CLOCK);
      #1 chk("keep", RETAIN_STATE, e);
      chk("idle", {REG_RESET, CPU_IDLE}, 2'h3);
      chk("regs", {MEMORY_BANK_SELECT, REGISTER_BANK_SELECT,
        INTERRUPT_STATUS_BIT0, INTERRUPT_STATUS_BIT1, CLEAR_CARRIERS,
        CLEAR_CLOCK_REGS, CLEAR_INTERRUPTS, CLEAR_EXT_INT_MODES},
        14'h3C0F);
      @(posedge CLOCK);
      RESET_PIN_B <= 1'b1;
      $display("pin test done");
    end
  endtask
  task t_run;
    begin
      n = 0;
      while (CPU_IDLE !== 1'b0 && n < 24'h00_07D0) begin
        @(posedge CLOCK);
        #1 n = n + 1;
      end
      chk("wait", (n >= STAB) && (n <= STAB + 8), 1'b1);
      chk("pc", PROGRAM_COUNTER, 14'h253C);
      chk("bank", {MEMORY_BANK_ENABLE, REGISTER_BANK_ENABLE}, 2'h2);
      $display("run test done");
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(posedge CLOCK);
    RST_B <= 1'b1;
    t_pin(1'b1, 1'b0, 1'b1);
    t_pin(1'b0, 1'b1, 1'b1);
    t_run;
    t_pin(1'b0, 1'b0, 1'b0);
    wrap_up;
  end
  initial begin
    #150000;
    error_cnt = error_cnt + 1;
    wrap_up;
  end
endmodule // testbench
